// file: rtl/bscl_ctrl.v
// bscl_ctrl.v: speed command, advance timing, current limit, lock faults
// assumes register writes arrive as one-cycle strobes from the serial slave
// and that analog quantities arrive as digital codes from the front end
`include "bscl_defs.vh"
module bscl_ctrl #(
	parameter LOCK_OFF_CYC = `BSCL_LOCK_OFF_MS * (1000000 / `BSCL_CLK_NS),
	parameter NLOCK        = 6
) (
	// clock and reset
	input  wire        i_sys_clk,
	input  wire        i_srst,
	// register writes from the serial slave
	input  wire        i_wr_low,
	input  wire        i_wr_high,
	input  wire [7:0]  i_wr_data,
	input  wire        i_serial_speed_select,
	input  wire [2:0]  i_closed_loop_rate_limit,
	input  wire [1:0]  i_feedback_attenuation,
	input  wire        i_advance_mode_select,
	input  wire [6:0]  i_advance_time_setting,
	input  wire [3:0]  i_accel_current_threshold,
	input  wire [6:0]  i_phase_resistance_setting,
	input  wire [6:0]  i_bemf_constant,
	input  wire [5:0]  i_lock_scheme_enables,
	input  wire [2:0]  i_lock_current_threshold,
	// motor side, outside the clock domain
	input  wire [8:0]  i_speed_pin_cmd,
	input  wire        i_closed_loop,
	input  wire [7:0]  i_speed_est,
	input  wire [8:0]  i_bemf_amp,
	input  wire [9:0]  i_current_fb,
	input  wire [7:0]  i_lowside_current,
	input  wire [5:0]  i_lock_detect,
	input  wire        i_overcurrent,
	// register read back
	output reg  [7:0]  o_speed_command_low,
	output reg  [7:0]  o_speed_command_high,
	output reg         o_motor_locked_flag,
	output reg  [5:0]  o_fault_cause_register,
	// bridge side
	output reg  [8:0]  o_amplitude,
	output reg  [9:0]  o_fb_scaled,
	output reg  [15:0] o_advance_ns,
	output reg         o_drive_en,
	output reg         o_anti_surge_process,
	output reg         o_restart
);
	////////////////////////////////////////////////////////////////////////
	localparam ST_RUN  = 2'd0;
	localparam ST_HIZ  = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_RST  = 2'd3;
	localparam [15:0] ADV_UNIT = `BSCL_ADV_UNIT_NS;
	localparam [31:0] WAIT_MAX = LOCK_OFF_CYC;
	localparam [4:0]  SURGE_LEN = `BSCL_SURGE_CYC;
	localparam [15:0] RATE_BASE = `BSCL_RATE_BASE_CYC;

	function [15:0] adv_ns;
		input [6:0] cfg;
		begin
			// settings above 65.5 us wrap: the port is only 16 bits wide
			adv_ns = (ADV_UNIT * {12'h000, cfg[3:0]}) << cfg[6:4];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	wire [8:0] pin_s;
	wire       cl_s;
	wire [7:0] spd_s;
	wire [8:0] bemf_s;
	wire [9:0] fb_s;
	wire [7:0] ls_s;
	wire [5:0] lk_s;
	wire       oc_s;
	bscl_sync2 #(.W(52)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_async   ({i_speed_pin_cmd, i_closed_loop, i_speed_est, i_bemf_amp,
		             i_current_fb, i_lowside_current, i_lock_detect,
		             i_overcurrent}),
		.o_sync    ({pin_s, cl_s, spd_s, bemf_s, fb_s, ls_s, lk_s, oc_s})
	);

	////////////////////////////////////////////////////////////////////////
	// speed command registers
	reg       hi_store_r;
	reg [8:0] serial_cmd_r;
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			hi_store_r   <= 1'b0;
			serial_cmd_r <= `BSCL_SPD_RST;
			o_speed_command_low  <= 8'h00;
			o_speed_command_high <= 8'h00;
		end else begin
			if (i_wr_high) begin
				hi_store_r <= i_wr_data[0]; // held only
				o_speed_command_high <= {7'h00, i_wr_data[0]};
			end
			if (i_wr_low) begin
				serial_cmd_r <= {hi_store_r, i_wr_data};
				o_speed_command_low <= i_wr_data;
			end
		end
	end

	// pin is not looked at while serial_speed_select is set
	wire [8:0] cmd_target = i_serial_speed_select ? serial_cmd_r : pin_s;

	// rate step enable divider; code 0 is fastest
	reg [15:0] rate_cnt_r;
	wire [15:0] rate_top = RATE_BASE << i_closed_loop_rate_limit;
	wire rate_step = (rate_cnt_r >= rate_top - 16'h0001);
	always @(posedge i_sys_clk) begin
		if (i_srst || rate_step)
			rate_cnt_r <= 16'h0000;
		else
			rate_cnt_r <= rate_cnt_r + 16'h0001;
	end

	wire [8:0] applied;
	bscl_rate_limit #(.W(`BSCL_SPD_W)) u_rate (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_step_en (rate_step),
		.i_bypass  (~cl_s), // limit applies only in closed loop
		.i_target  (cmd_target),
		.o_applied (applied)
	);

	////////////////////////////////////////////////////////////////////////
	// acceleration current limit: no current measured
	wire [17:0] u_limit = {11'h000, i_accel_current_threshold, 3'h0}
	                      * {11'h000, i_phase_resistance_setting}
	                      + {3'h0, spd_s} * {8'h00, i_bemf_constant} >> 4;
	wire        lim_hit = cl_s && ({9'h000, applied} > u_limit);
	// full scale is 0x1FF limiting is no fault
	wire [8:0]  amp_nxt = lim_hit ? u_limit[8:0] : applied;

	// advance time: mode 1 scales by (u - bemf)/u
	wire [15:0] t_set = adv_ns(i_advance_time_setting);
	wire [8:0]  margin = (amp_nxt > bemf_s) ? amp_nxt - bemf_s : 9'h000;
	wire [24:0] scaled = t_set * margin;
	wire [24:0] quot   = scaled / {16'h0000, amp_nxt};
	wire [15:0] adv_nxt = !i_advance_mode_select ? t_set :
	                      (amp_nxt == 9'h000) ? 16'h0000 :
	                      quot[15:0];

	////////////////////////////////////////////////////////////////////////
	// fault handling
	reg [1:0]  st_r;
	reg [31:0] wait_r;
	reg [4:0]  surge_r;
	// scheme 0 derives from low-side current threshold
	wire [5:0] raw = {lk_s[5:1],
	                  ls_s > {i_lock_current_threshold, 5'h1F}};
	wire       trip = |(raw & i_lock_scheme_enables);
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_r    <= ST_RUN;
			wait_r  <= 32'h0;
			surge_r <= 5'h00;
			o_motor_locked_flag    <= 1'b0;
			o_fault_cause_register <= 6'h00;
			o_restart <= 1'b0;
		end else begin
			o_restart <= 1'b0;
			// cause recorded even when disabled
			o_fault_cause_register <= o_fault_cause_register | raw;
			case (st_r)
			ST_RUN: begin
				if (trip) begin
					st_r <= ST_HIZ; // enter lock
					o_motor_locked_flag <= 1'b1;
					surge_r <= SURGE_LEN;
				end
			end
			ST_HIZ: begin
				if (surge_r == 5'h00) begin
					st_r   <= ST_WAIT;
					wait_r <= 32'h0;
				end else
					surge_r <= surge_r - 5'h01;
			end
			ST_WAIT: begin
				if (wait_r >= WAIT_MAX - 32'h1)
					st_r <= ST_RST;
				else
					wait_r <= wait_r + 32'h1;
			end
			ST_RST: begin
				st_r <= ST_RUN;
				o_restart <= 1'b1;
				o_motor_locked_flag <= 1'b0;
				o_fault_cause_register <= raw; // reloaded with the current raw conditions on restart
			end
			default: st_r <= ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_amplitude  <= 9'h000;
			o_fb_scaled  <= 10'h000;
			o_advance_ns <= 16'h0000;
			o_drive_en   <= 1'b0;
			o_anti_surge_process <= 1'b0;
		end else begin
			o_amplitude  <= amp_nxt;
			o_fb_scaled  <= fb_s >> i_feedback_attenuation;
			o_advance_ns <= adv_nxt;
			// overcurrent gates drive until it clears
			o_drive_en   <= (st_r == ST_RUN) && !trip && !oc_s;
			o_anti_surge_process <= (st_r == ST_HIZ) ||
			                        (st_r == ST_RUN && trip);
		end
	end
endmodule // bscl_ctrl

// file: rtl/bscl_defs.vh
// bscl_defs.vh: constants for the speed command and lock fault block
// assumes plain verilog-2005 users include it by bare name
// Function
// - serial serial_speed_select bit set selects speed command from written serial values
// - while serial_speed_select is active the speed pin input is ignored
// - nine-bit command sets peak amplitude, 0x1FF is maximum
// - writing the upper bit only stores it, active command unchanged
// - writing low byte updates command with stored upper bit; upper first
// - applied command change rate limited in closed loop by 3-bit field
// - 2-bit coefficient attenuates current feedback used by closed loop
// - advance mode 0 gives constant advance equal to setting
// - advance mode 1 scales setting by (amplitude minus bemf) over amplitude
// - setting is 2.5 us times mantissa shifted left by exponent
// - accel limit caps voltage at threshold times resistance plus speed term
// - accel limit keeps motor running with no fault and no stop
// - accel limit acts only in closed loop
// - lock current limit trip stops drive, enters lock, reports rotation error
// - phase overcurrent stops drive until indication clears, never disabled
// - six-bit enable field disables each lock scheme and no-motor check
// - any lock condition sets the motor locked status flag
// - fault cause bits show which condition occurred, cleared on restart; the code reloads them with the raw conditions present at restart
// - fault cause bits set even when that scheme is disabled
// - lock or no-motor puts drivers in high impedance with anti-surge
// - after fault high impedance, restart attempted after lock-off wait
// - lock current limit trips when low-side current exceeds 3-bit threshold
`ifndef BSCL_DEFS_VH
`define BSCL_DEFS_VH
`define BSCL_SPD_W          9
`define BSCL_SPD_MAX        9'h1FF
`define BSCL_SPD_RST        9'h000
`define BSCL_ADV_MANT_LSB   0
`define BSCL_ADV_EXP_LSB    4
`define BSCL_ADV_UNIT_NS    2500
`define BSCL_CLK_NS         20
`define BSCL_LOCK_OFF_MS    5000
`define BSCL_RATE_BASE_CYC  64
`define BSCL_SURGE_CYC      16
`endif

// file: rtl/bscl_rate_limit.v
// bscl_rate_limit.v: steps an applied command toward a target
// assumes a one-cycle step enable from the caller's divider
`include "bscl_defs.vh"
module bscl_rate_limit #(
	parameter W = 9
) (
	// clock and reset
	input  wire         i_sys_clk,
	input  wire         i_srst,
	// control
	input  wire         i_step_en,
	input  wire         i_bypass,
	input  wire [W-1:0] i_target,
	// result
	output reg  [W-1:0] o_applied
);
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_applied <= {W{1'b0}};
		end else if (i_bypass) begin
			o_applied <= i_target;
		end else if (i_step_en) begin
			// one lsb per enable bounds the slope
			if (o_applied < i_target)
				o_applied <= o_applied + {{(W-1){1'b0}}, 1'b1};
			else if (o_applied > i_target)
				o_applied <= o_applied - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // bscl_rate_limit

// file: rtl/bscl_sync2.v
// bscl_sync2.v: two-flop synchroniser for a bus of levels
// assumes inputs come from outside the clock domain
module bscl_sync2 #(
	parameter W = 1
) (
	// clock
	input  wire         i_sys_clk,
	// data
	input  wire [W-1:0] i_async,
	output reg  [W-1:0] o_sync
);
	reg [W-1:0] meta_r;
	always @(posedge i_sys_clk) begin
		meta_r <= i_async;
		o_sync <= meta_r;
	end
endmodule // bscl_sync2

// file: testbench/bscl_ctrl_chk.sv
// bscl_ctrl_chk.sv: port checks for the speed command block
// assumes it is bound to bscl_ctrl and sees only its ports
module bscl_ctrl_chk (
	// clock and reset
	input logic       i_sys_clk,
	input logic       i_srst,
	// inputs
	input logic       i_wr_low,
	input logic       i_wr_high,
	input logic [7:0] i_wr_data,
	input logic       i_overcurrent,
	// outputs
	input logic [7:0] o_speed_command_low,
	input logic [7:0] o_speed_command_high,
	input logic       o_motor_locked_flag,
	input logic [5:0] o_fault_cause_register,
	input logic       o_drive_en,
	input logic       o_anti_surge_process,
	input logic       o_restart
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////
	AST_LOW_RB: assert property (i_wr_low |=>
		o_speed_command_low == $past(i_wr_data)) else $error("low byte");
	AST_HIGH_RB: assert property (i_wr_high |=>
		o_speed_command_high[0] == $past(i_wr_data[0])) else $error("hi");
	AST_LOCK_STOP: assert property ($rose(o_motor_locked_flag) |->
		!o_drive_en && o_anti_surge_process) else $error("lock stop");
	AST_FLAG_CAUSE: assert property (o_motor_locked_flag |->
		o_fault_cause_register != 6'h00) else $error("no cause");
	AST_SURGE: assert property ($rose(o_anti_surge_process) |->
		o_anti_surge_process[*8]) else $error("surge short");
	AST_NO_EARLY: assert property ($rose(o_motor_locked_flag) |->
		!o_restart[*8]) else $error("early restart");
	AST_RST_CLR: assert property (o_restart |->
		##[0:1] !o_motor_locked_flag) else $error("flag kept");
	AST_OC: assert property (i_overcurrent[*4] |-> !o_drive_en)
		else $error("drive in overcurrent");
endmodule // bscl_ctrl_chk

bind bscl_ctrl bscl_ctrl_chk u_chk (.i_sys_clk, .i_srst, .i_wr_low,
	.i_wr_high, .i_wr_data, .i_overcurrent, .o_speed_command_low,
	.o_speed_command_high, .o_motor_locked_flag, .o_fault_cause_register,
	.o_drive_en, .o_anti_surge_process, .o_restart);

// file: testbench/bscl_ctrl_tb_top.sv
// bscl_ctrl_tb_top.sv: self-checking bench for bscl_ctrl
// assumes the host model and bound checker are compiled first
`define CHK(a, b) begin #1; checked++; if ((a) !== (b)) begin \
	n_fail++; $display("[FAIL] %0t got %h", $time, a); end end
module bscl_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 0, srst = 1, sel = 0, mode = 0, cl = 0, oc = 0;
	logic [2:0] rate = 3'h0, lthr = 3'h7;
	logic [1:0] att = 2'h0;
	logic [6:0] adv = 7'h19, res = 7'h00, kt = 7'h00;
	logic [3:0] athr = 4'h0;
	logic [5:0] en = 6'h3F, det = 6'h00, cause;
	logic [8:0] pin = 9'h0AA, bemf = 9'h000, amp;
	logic [7:0] spd = 8'h00, ls = 8'h00, wd, rlo, rhi;
	logic [9:0] fb = 10'h3FF, fbs;
	logic [15:0] advns;
	logic       wl, wh, lck, den, srg, rst_p;
	int         n_fail = 0, checked = 0, cyc = 0;
	////////////////////////////////////////
	bscl_host host (.i_sys_clk(clk), .o_wr_low(wl), .o_wr_high(wh),
		.o_wr_data(wd));
	bscl_ctrl #(.LOCK_OFF_CYC(200)) dut (
		.i_sys_clk(clk), .i_srst(srst), .i_wr_low(wl), .i_wr_high(wh),
		.i_wr_data(wd), .i_serial_speed_select(sel),
		.i_closed_loop_rate_limit(rate), .i_feedback_attenuation(att),
		.i_advance_mode_select(mode), .i_advance_time_setting(adv),
		.i_accel_current_threshold(athr), .i_phase_resistance_setting(res),
		.i_bemf_constant(kt), .i_lock_scheme_enables(en),
		.i_lock_current_threshold(lthr), .i_speed_pin_cmd(pin),
		.i_closed_loop(cl), .i_speed_est(spd), .i_bemf_amp(bemf),
		.i_current_fb(fb), .i_lowside_current(ls), .i_lock_detect(det),
		.i_overcurrent(oc), .o_speed_command_low(rlo),
		.o_speed_command_high(rhi), .o_motor_locked_flag(lck),
		.o_fault_cause_register(cause), .o_amplitude(amp),
		.o_fb_scaled(fbs), .o_advance_ns(advns), .o_drive_en(den),
		.o_anti_surge_process(srg), .o_restart(rst_p));
	initial forever #10 clk = ~clk;
	task stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin // whole run is about 4900 cycles
		cyc++;
		if (cyc == 9000) begin
			n_fail++;
			stop_test;
		end
	end
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////
	initial begin
		int k;
		wt(10);
		srst <= 1'b0;
		wt(1);
		sel <= 1'b1;
		host.wr(1'b1, 1'b1, 9'h1FF);
		wt(4);
		`CHK(rlo, 8'hFF)
		`CHK(rhi[0], 1'b1)
		`CHK(amp, 9'h1FF)
		wt(1);
		pin <= 9'h000;
		host.wr(1'b1, 1'b0, 9'h000);
		wt(6);
		`CHK(amp, 9'h1FF)
		host.wr(1'b0, 1'b1, 9'h034);
		wt(4);
		`CHK(amp, 9'h034)
		wt(1);
		{athr, res, cl} <= {4'hF, 7'h7F, 1'b1};
		host.wr(1'b0, 1'b1, 9'h040);
		wt(4);
		`CHK(amp < 9'h036, 1'b1)
		wt(850);
		`CHK(amp, 9'h040)
		for (int a = 0; a < 4; a++) begin
			wt(1);
			att <= a[1:0];
			wt(4);
			`CHK(fbs, 10'h3FF >> a)
		end
		`CHK(advns, 16'hAFC8)
		wt(1);
		{mode, bemf, athr, res} <= {1'b1, 9'h1FF, 4'h1, 7'h10};
		wt(4);
		`CHK(advns, 16'h0000)
		wt(3700);
		`CHK(amp, 9'h008)
		`CHK({lck, den}, 2'b01)
		wt(1);
		oc <= 1'b1;
		wt(5);
		`CHK(den, 1'b0)
		wt(1);
		oc <= 1'b0;
		wt(5);
		`CHK(den, 1'b1)
		wt(1);
		det <= 6'h08;
		wt(6);
		`CHK({lck, den, srg, cause}, 9'h148)
		wt(1);
		det <= 6'h00;
		for (k = 0; k < 400 && rst_p !== 1'b1; k++)
			wt(1);
		`CHK(k > 190 && k < 400, 1'b1)
		wt(3);
		`CHK({lck, cause}, 7'h00)
		wt(1);
		{en, det, ls} <= {6'h3B, 6'h04, 8'hFF};
		wt(6);
		`CHK({lck, cause}, 7'h04)
		wt(1);
		lthr <= 3'h6;
		wt(6);
		`CHK({lck, cause}, 7'h45)
		stop_test;
	end
endmodule // bscl_ctrl_tb_top

// file: testbench/bscl_host.sv
// bscl_host.sv: host model writing the speed command registers
// assumes strobes are taken on the rising edge
module bscl_host (
	// clock
	input  logic       i_sys_clk,
	// write strobes
	output logic       o_wr_low = 1'b0,
	output logic       o_wr_high = 1'b0,
	output logic [7:0] o_wr_data = 8'h00
);
	// data is inverted once released, so stale values are never read
	task wr(input logic hi, input logic lo, input logic [8:0] v);
		if (hi) begin // upper bit goes first
			@(posedge i_sys_clk);
			{o_wr_high, o_wr_data} <= {1'b1, 7'h00, v[8]};
			@(posedge i_sys_clk);
			{o_wr_high, o_wr_data} <= {1'b0, ~o_wr_data};
		end
		if (lo) begin // low byte completes the pair
			@(posedge i_sys_clk);
			{o_wr_low, o_wr_data} <= {1'b1, v[7:0]};
			@(posedge i_sys_clk);
			{o_wr_low, o_wr_data} <= {1'b0, ~o_wr_data};
		end
	endtask
endmodule // bscl_host
